// File: core/flso_pkg.sv
// Operation
// - analog code proportional to fault distance
// - four contacts: phases A, B, C, neutral
// - static switch selects current or voltage range
// - 100 percent line gives 80 percent scale
// - above 110 percent forces full scale
// - lockout blocks later faults from updating
// - clear period expiry forces full scale, opens
// - date/time change clears timers and output
package flso_pkg;
  // converter code width and full scale value
  localparam int unsigned CODE_W        = 12;
  localparam logic [11:0] CODE_FULL     = 12'hfff;
  // fault location in tenths of a percent of line length
  localparam int unsigned LOC_W         = 12;
  localparam logic [11:0] LOC_LIMIT     = 12'h44c;  // 110.0 percent
  // scale: 100.0 percent (1000) maps to 80 percent of 4095
  localparam int unsigned SCALE_NUM     = 3276;
  localparam int unsigned SCALE_DEN     = 1000;
  // timer width and a millisecond tick from the 250 MHz clock
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYC      = CLK_MHZ * TICK_US;
  localparam int unsigned TMR_W         = 16;
  localparam logic [15:0] TMR_ZERO      = 16'h0000;

  // fault type as four contact bits
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic n;
  } flso_type_s;

  // one fault result from the location calculation
  typedef struct packed {
    logic [11:0] loc;
    flso_type_s  kind;
  } flso_fault_s;
endpackage : flso_pkg

// File: core/flso_tick.sv
`timescale 1ns/10ps
`default_nettype none
// divider giving a one-cycle enable each period
module flso_tick #(
  parameter int unsigned PERIOD = flso_pkg::TICK_CYC
) (
  input  wire logic clk_sys_in,  // system clock
  input  wire logic rst_in,      // sync reset, high
  output logic      tick_out     // one-cycle enable
);
  typedef struct packed {
    logic [31:0] cnt;  // cycles into period
    logic        tick; // registered pulse
  } flso_tick_s;
  flso_tick_s st;
  flso_tick_s next_st;

  // wrap counter and raise the pulse at the end
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt >= 32'(PERIOD - 1)) begin
      next_st.cnt  = 32'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  // register the state
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;
endmodule : flso_tick
`default_nettype wire

// File: core/flso_scada_output.sv
`timescale 1ns/10ps
`default_nettype none
// scada output module: fault distance code and fault type contacts
module flso_scada_output #(
  parameter int unsigned TICK_PERIOD = flso_pkg::TICK_CYC  // cycles per timer tick
) (
  input  wire logic                    clk_sys_in,             // system clock
  input  wire logic                    rst_in,                 // sync reset, high
  input  wire logic                    fault_valid_in,         // one-cycle result strobe
  input  wire flso_pkg::flso_fault_s   fault_in,               // location and type
  input  wire logic [15:0]             update_lockout_period_in, // lockout, ticks
  input  wire logic [15:0]             output_clear_period_in, // clear delay, ticks
  input  wire logic                    date_time_change_in,    // clock setting changed
  input  wire logic                    range_voltage_in,       // static range switch
  output logic [11:0]                  code_out,               // converter code
  output flso_pkg::flso_type_s         contacts_out,           // closed when high
  output logic                         range_voltage_out,      // range to converter
  output logic                         lockout_active_out      // lockout running
);
  typedef struct packed {
    logic [11:0]          code;   // stored output code
    flso_pkg::flso_type_s cont;   // stored contacts
    logic [15:0]          lock;   // lockout ticks left
    logic [15:0]          clr;    // clear ticks left
    logic                 clr_on; // clear timer running
    logic                 rng;    // sampled range switch
    logic                 lock_on; // lockout running, registered for the pin
  } flso_st_s;
  flso_st_s st;
  flso_st_s next_st;
  logic     tick;
  logic     load;
  logic [23:0] prod;

  // millisecond enable for both timers
  flso_tick #(.PERIOD(TICK_PERIOD)) u_tick (
    .clk_sys_in(clk_sys_in),
    .rst_in    (rst_in),
    .tick_out  (tick)
  );

  assign load = fault_valid_in && (st.lock == flso_pkg::TMR_ZERO);
  // scale 100 percent to 80 percent
  assign prod = 24'(fault_in.loc * 24'(flso_pkg::SCALE_NUM) / flso_pkg::SCALE_DEN);

  // next state: load, timers, clear and date change
  always_comb begin
    next_st = st;
    next_st.rng = range_voltage_in;
    // timers count down on the tick
    if (tick && st.lock != flso_pkg::TMR_ZERO) begin
      next_st.lock = st.lock - 16'h1;
    end
    if (tick && st.clr_on) begin
      if (st.clr == flso_pkg::TMR_ZERO) begin
        next_st.clr_on = 1'b0;
        next_st.code   = flso_pkg::CODE_FULL;
        next_st.cont   = '0;
      end else begin
        next_st.clr = st.clr - 16'h1;
      end
    end
    if (load) begin
      if (fault_in.loc > flso_pkg::LOC_LIMIT) begin
        next_st.code = flso_pkg::CODE_FULL;
      end else begin
        next_st.code = prod[11:0];
      end
      next_st.cont   = fault_in.kind;
      next_st.lock   = update_lockout_period_in;
      next_st.clr    = output_clear_period_in;
      next_st.clr_on = 1'b1;
    end
    if (date_time_change_in) begin
      next_st.lock   = flso_pkg::TMR_ZERO;
      next_st.clr    = flso_pkg::TMR_ZERO;
      next_st.clr_on = 1'b0;
      next_st.code   = flso_pkg::CODE_FULL;
      next_st.cont   = '0;
    end
    // flag kept in a flop so the output pin has no decode glitch
    next_st.lock_on = (next_st.lock != flso_pkg::TMR_ZERO);
  end

  // register state; reset parks output invalid
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st.code   <= flso_pkg::CODE_FULL;
      st.cont   <= '0;
      st.lock   <= flso_pkg::TMR_ZERO;
      st.clr    <= flso_pkg::TMR_ZERO;
      st.clr_on <= 1'b0;
      st.rng    <= 1'b0;
      st.lock_on <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign code_out           = st.code;
  assign contacts_out       = st.cont;
  assign range_voltage_out  = st.rng;
  assign lockout_active_out = st.lock_on;

  a_limit_full_scale: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    load && fault_in.loc > flso_pkg::LOC_LIMIT && !date_time_change_in
      |=> code_out == flso_pkg::CODE_FULL) else $error("over limit not full scale");
  a_lockout_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    fault_valid_in && lockout_active_out && !date_time_change_in && !tick
      |=> $stable(contacts_out)) else $error("update during lockout");
  a_date_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    date_time_change_in |=> code_out == flso_pkg::CODE_FULL && contacts_out == '0
      && !lockout_active_out) else $error("date change did not clear");
  a_contacts_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    load && !date_time_change_in |=> contacts_out == $past(fault_in.kind))
    else $error("contacts not loaded");
  a_code_scale: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    load && fault_in.loc <= flso_pkg::LOC_LIMIT && !date_time_change_in
      |=> code_out == $past(prod[11:0])) else $error("code not scaled");
  a_range_track: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    1'b1 |=> range_voltage_out == $past(range_voltage_in)) else $error("range wrong");
  // first cycle after reset is invalid
  a_reset_park: assert property (@(posedge clk_sys_in)
    rst_in |=> code_out == flso_pkg::CODE_FULL && contacts_out == '0)
    else $error("reset not parked");
  a_load_lock: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    load && !date_time_change_in |=> st.lock == $past(update_lockout_period_in))
    else $error("lockout not started");
  a_clear_expire: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    tick && st.clr_on && st.clr == flso_pkg::TMR_ZERO && !load
      |=> code_out == flso_pkg::CODE_FULL && contacts_out == '0) else $error("clear missed");
endmodule : flso_scada_output
`default_nettype wire

// File: sim/flso_rtu_model.sv
`timescale 1ns/10ps
`default_nettype none
// remote unit inputs: one analog port, four digital ports
module flso_rtu_model (
  input  wire logic                 clk_sys_in,     // system clock
  input  wire logic [11:0]          code_in,        // analog port
  input  wire flso_pkg::flso_type_s contacts_in,    // digital ports
  output logic                      reading_ok_out, // distance usable
  output flso_pkg::flso_type_s      seen_out        // sampled contacts
);
  // samples like a scan; full scale never counts as a distance
  // full scale invalid
  always_ff @(posedge clk_sys_in) begin
    reading_ok_out <= (code_in !== flso_pkg::CODE_FULL);
    seen_out       <= contacts_in;
  end
endmodule : flso_rtu_model
`default_nettype wire

// File: sim/fault_location_scada_output_tb.sv
`timescale 1ns/10ps
`default_nettype none
// bench: strobed results, timers and date change against expectations
module fault_location_scada_output_tb;
  logic                  clk_sys_in = 1'b0; // system clock
  logic                  rst_in     = 1'b1; // sync reset
  logic                  vld        = 1'b0; // result strobe
  flso_pkg::flso_fault_s flt        = '0;   // location and type
  logic [15:0]           lock_p     = '0;   // lockout ticks
  logic [15:0]           clr_p      = '1;   // clear ticks
  logic                  dtc        = 1'b0; // date or time changed
  logic                  rng        = 1'b1; // voltage range
  logic [11:0]           code;              // converter code
  flso_pkg::flso_type_s  cont;              // contacts
  logic                  rng_o;             // range copy
  logic                  lock_o;            // lockout running
  logic                  ok;                // remote unit verdict
  flso_pkg::flso_type_s  seen;              // remote unit contacts
  int                    num_errors   = 0;  // mismatches
  int                    total_checks = 0;  // comparisons
  int                    cyc          = 0;  // timeout counter

  always #2 clk_sys_in = ~clk_sys_in;

  // short tick keeps the timers to tens of cycles
  flso_scada_output #(.TICK_PERIOD(4)) dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .fault_valid_in(vld), .fault_in(flt),
    .update_lockout_period_in(lock_p), .output_clear_period_in(clr_p),
    .date_time_change_in(dtc), .range_voltage_in(rng), .code_out(code),
    .contacts_out(cont), .range_voltage_out(rng_o), .lockout_active_out(lock_o));
  flso_rtu_model rtu (.clk_sys_in(clk_sys_in), .code_in(code), .contacts_in(cont),
    .reading_ok_out(ok), .seen_out(seen));

  // compare and count
  task check(input string name, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // expected code: linear scale, full scale past the limit
  function automatic logic [11:0] exp_code(input logic [11:0] l);
    if (l > 12'h44c) return 12'hfff;
    return 12'((32'(l) * 3276) / 1000);
  endfunction : exp_code

  // one strobed result, then settle one cycle
  task load(input logic [11:0] l, input logic [3:0] k);
    @(negedge clk_sys_in);
    vld = 1'b1;
    flt = {l, k};
    @(negedge clk_sys_in);
    vld = 1'b0;
    @(negedge clk_sys_in);
  endtask : load

  // bounded wait, up to 60 cycles, for the converter code to reach a value
  task wait_for(input logic [11:0] want);
    for (int n = 0; n < 60 && code !== want; n++) @(negedge clk_sys_in);
  endtask : wait_for

  task give_verdict;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // hang guard, far above the planned run
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    logic [11:0] l;
    logic [3:0]  k;
    logic [11:0] corner [5] = '{12'h000, 12'h3e8, 12'h44c, 12'h44d, 12'hfff};
    void'($urandom(32'h67481b8a));
    repeat (16) @(negedge clk_sys_in);
    rst_in = 1'b0;
    @(negedge clk_sys_in);
    check("code", 16'(code), 16'hfff);
    check("cont", 16'(cont), 16'h0);
    check("rtu", 16'(ok), 16'h0);
    check("range", 16'(rng_o), 16'h1);
    // corners first, then random in-range results back to back
    for (int i = 0; i < 25; i++) begin
      l = (i < 5) ? corner[i] : 12'($urandom_range(1100));
      k = (i == 1) ? 4'b0111 : 4'($urandom);
      load(l, k);
      check("code", 16'(code), 16'(exp_code(l)));
      check("cont", 16'(cont), 16'(k));
      check("rtu", 16'(ok), 16'(exp_code(l) != 12'hfff));
      check("seen", 16'(seen), 16'(k));
    end
    lock_p = 16'h0003;
    load(12'd400, 4'b1000);
    check("lock", 16'(lock_o), 16'h1);
    load(12'd900, 4'b0001);
    check("code", 16'(code), 16'(exp_code(12'd400)));
    for (int n = 0; n < 60 && lock_o !== 1'b0; n++) @(negedge clk_sys_in);
    load(12'd900, 4'b0001);
    check("code", 16'(code), 16'(exp_code(12'd900)));
    lock_p = '0;
    // the second accepted load restarted the lockout; let it run out
    for (int n = 0; n < 60 && lock_o !== 1'b0; n++) @(negedge clk_sys_in);
    check("lock", 16'(lock_o), 16'h0);
    clr_p  = 16'h0002;
    load(12'd500, 4'b0110);
    check("code", 16'(code), 16'(exp_code(12'd500)));
    wait_for(12'hfff);
    check("code", 16'(code), 16'hfff);
    check("cont", 16'(cont), 16'h0);
    clr_p  = '1;
    lock_p = 16'h0064;
    load(12'd300, 4'b1111);
    dtc = 1'b1;
    @(negedge clk_sys_in);
    dtc = 1'b0;
    @(negedge clk_sys_in);
    check("code", 16'(code), 16'hfff);
    check("cont", 16'(cont), 16'h0);
    check("lock", 16'(lock_o), 16'h0);
    give_verdict();
  end
endmodule : fault_location_scada_output_tb
`default_nettype wire
